// ### bmp_pkg.sv
// Shared constants for the buck mode and pulse control block.
// Assumes a 50 MHz reference clock; the cycle counts given in ns derive from it.
package bmp_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned SLEEP_DLY_NS = 103000;
  // Longest wait, so round down
  localparam int unsigned SLEEP_DLY_CYC = SLEEP_DLY_NS * CLK_MHZ / 1000;
  localparam int unsigned BURST_ENTRY_CYC = 2048;
  localparam int unsigned WAKE_DLY_NS = 2500;
  localparam int unsigned WAKE_DLY_CYC = WAKE_DLY_NS * CLK_MHZ / 1000;
  localparam int unsigned MIN_ON_NS = 95;
  localparam int unsigned MIN_ON_CYC = MIN_ON_NS * CLK_MHZ / 1000;
  localparam int unsigned MAX_ON_NS = 1000;
  localparam int unsigned MAX_ON_CYC = MAX_ON_NS * CLK_MHZ / 1000;
  localparam int unsigned OSC_DIV = 25;
  localparam int unsigned SYNC_WIN_CYC = 64;
  localparam int unsigned TMR_W = 13;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam int unsigned CTRL_BURST_EN = 0;
  localparam int unsigned CTRL_SYNC_EN = 1;
  localparam int unsigned IRQ_W = 6;
  localparam int unsigned EV_SLEEP = 0;
  localparam int unsigned EV_BURST = 1;
  localparam int unsigned EV_REDUCED = 2;
  localparam int unsigned EV_BOOT_OV = 3;
  localparam int unsigned EV_BOOT_UV = 4;
  localparam int unsigned EV_SYNC = 5;
  localparam int unsigned STAT_SYNC = 5;
  localparam int unsigned STAT_GATE = 6;

  // ----------------------------------------------------------------
  // Fault inputs
  // ----------------------------------------------------------------
  localparam int unsigned FLT_W = 4;
  localparam int unsigned FLT_BOOT_OV = 0;
  localparam int unsigned FLT_BOOT_UV = 1;
  localparam int unsigned FLT_SHORT = 2;
  localparam int unsigned FLT_THERMAL = 3;
  // Thermal detector is debiased in burst mode
  localparam logic [3:0] DET_BURST = 4'h7;
  localparam logic [3:0] DET_ALL = 4'hF;

  typedef enum logic [4:0] {
    ST_SLEEP = 5'h01,
    ST_FIXED = 5'h02,
    ST_WAIT = 5'h04,
    ST_BURST = 5'h08,
    ST_REDUCED = 5'h10
  } bmp_state_t;

endpackage

// ### bmp_delay_timer.sv
// Up counter that reports when a run of the enable reaches a count.
// Assumes run_in comes from logic on the same clock.
`timescale 1ns/100ps
module bmp_delay_timer #(
  parameter int unsigned W = 13
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Control
  input wire logic run_in,
  input wire logic [W-1:0] count_in,
  output logic done_out
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  assign done_out = run_in && (cnt_reg == count_in);

  always_comb begin
    cnt_next = cnt_reg;
    if (!run_in) begin
      cnt_next = '0;
    end else if (cnt_reg != count_in) begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= '0;
    end else if (ce_in) begin
      cnt_reg <= cnt_next;
    end
  end
endmodule // bmp_delay_timer

// ### bmp_sync_detect.sv
// Synchroniser and clock-activity detector for the mode-select pin.
// Assumes the pin is asynchronous; a clock on it is slower than ref/4.
`timescale 1ns/100ps
module bmp_sync_detect #(
  parameter int unsigned WIN = 64
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Pin and results
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out,
  output logic clk_present_out
);
  logic s1_reg, s2_reg, s3_reg;
  logic [7:0] win_reg, win_next;
  logic [1:0] edges_reg, edges_next;
  logic present_reg, present_next;

  assign level_out = s2_reg;
  assign rise_out = s2_reg && !s3_reg;
  assign clk_present_out = present_reg;

  // Two or more rising edges per window mean a clock, not a level
  always_comb begin
    win_next = win_reg + 8'h01;
    edges_next = edges_reg;
    present_next = present_reg;
    if (rise_out && edges_reg != 2'h3) begin
      edges_next = edges_reg + 2'h1;
    end
    if (win_reg == 8'(WIN - 1)) begin
      win_next = 8'h00;
      present_next = (edges_next >= 2'h2);
      edges_next = 2'h0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      win_reg <= 8'h00;
      edges_reg <= 2'h0;
      present_reg <= 1'b0;
    end else if (ce_in) begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      win_reg <= win_next;
      edges_reg <= edges_next;
      present_reg <= present_next;
    end
  end
endmodule // bmp_sync_detect

// ### bmp_mode_ctrl.sv
// Mode sequencing, switch latch and APB registers of the buck control.
// Assumes analog comparator and fault flags arrive asynchronously.
//
// What this block does
// RULE1 - Regulate only while shutdown input is high
// RULE2 - Shut down after about 103 us low
// RULE3 - Mode high fixed frequency, low burst
// RULE4 - Burst entry needs soft-start, power-good, 2048 cycles
// RULE5 - Shutdown ignores mode input, output held off
// RULE6 - Burst with fault runs half-limit fixed frequency
// RULE7 - Lock switching to clock on mode pin
// RULE8 - Bias loss resets, stops switching, pulls nodes
// RULE9 - Fault or shutdown pulls comp, blocks pulses
// RULE10 - Cycle clock sets latch, comparator clears it
// RULE11 - Latch reset-dominant, blocked clock skips period
// RULE12 - On-pulses down to about 95 ns
// RULE13 - Fixed frequency enables every fault detector
// RULE14 - Boot capacitor open or short flagged
// RULE15 - Burst wake, 2.5 us wait, then pulse
// RULE16 - Reduced mode only on burst fault, all detectors
// RULE17 - Clock told from level by edge count
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module bmp_mode_ctrl #(
  parameter int unsigned SLEEP_DLY_CYC = bmp_pkg::SLEEP_DLY_CYC,
  parameter int unsigned OSC_DIV = bmp_pkg::OSC_DIV,
  parameter int unsigned MAX_ON_CYC = bmp_pkg::MAX_ON_CYC
) (
  // Clock, enable, reset
  input wire logic ref_clk_in,
  input wire logic ce_in,
  input wire logic rst_n_in,
  // Pins from the host
  input wire logic sleep_n_in,
  input wire logic mode_select_sync_in,
  // Analog status
  input wire logic cs_trip_in,
  input wire logic fb_below_ref_in,
  input wire logic ss_above_thr_in,
  input wire logic vout_ok_in,
  input wire logic bias_lost_in,
  input wire logic [3:0] fault_in,
  // Power stage and analog controls
  output logic hs_gate_out,
  output logic comp_pull_out,
  output logic ss_pull_out,
  output logic power_good_n_out,
  output logic peak_current_limit_half_out,
  output logic detectors_en_out,
  output logic irq_out,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam int unsigned TW = bmp_pkg::TMR_W;
  localparam int unsigned NA = 5 + bmp_pkg::FLT_W;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [NA-1:0] async_w, s1_reg, s2_reg;
  logic [bmp_pkg::FLT_W-1:0] flt_d_reg;
  logic sleep_n_s, cs_trip_s, fb_below_s, ss_ok_s, vout_ok_s, bias_s, sleep_s1_reg, sleep_s2_reg;
  logic [bmp_pkg::FLT_W-1:0] fault_s;

  assign async_w = {fault_in, bias_lost_in, vout_ok_in, ss_above_thr_in,
                    fb_below_ref_in, cs_trip_in};
  assign {fault_s, bias_s, vout_ok_s, ss_ok_s, fb_below_s, cs_trip_s} = s2_reg;
  assign sleep_n_s = sleep_s2_reg;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
      flt_d_reg <= '0;
      sleep_s1_reg <= 1'b0;
      sleep_s2_reg <= 1'b0;
    end else if (ce_in) begin
      s1_reg <= async_w;
      s2_reg <= s1_reg;
      flt_d_reg <= fault_s;
      sleep_s1_reg <= sleep_n_in;
      sleep_s2_reg <= sleep_s1_reg;
    end
  end

  logic mode_level, sync_rise, clk_present;
  bmp_sync_detect #(.WIN(bmp_pkg::SYNC_WIN_CYC)) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .pin_in(mode_select_sync_in),
    .level_out(mode_level),
    .rise_out(sync_rise),
    .clk_present_out(clk_present)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [1:0] ctrl_reg, ctrl_next;
  logic [bmp_pkg::IRQ_W-1:0] irq_reg, irq_next, mask_reg, mask_next, ev;
  logic [31:0] prdata_next;
  logic ack_reg, ack_next, apb_done;
  bmp_pkg::bmp_state_t state_reg, state_next;
  logic wake_reg, wake_next, latch_reg, latch_next;
  logic [7:0] div_reg, div_next;
  logic present_d_reg;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == bmp_pkg::REG_CTRL) || (a == bmp_pkg::REG_STATUS) ||
              (a == bmp_pkg::REG_IRQ_STAT) || (a == bmp_pkg::REG_IRQ_MASK);
  endfunction

  // One wait state: data captured in the first access cycle
  assign pready = psel && penable && ack_reg;
  assign apb_done = pready;
  assign pslverr = pready && !addr_ok(paddr);

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  logic shutdown, entry_done, wake_done, on_max;
  bmp_delay_timer #(.W(TW)) u_sleep_tmr (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .run_in(!sleep_n_s), .count_in(TW'(SLEEP_DLY_CYC)),
    .done_out(shutdown)
  ); // RULE2
  bmp_delay_timer #(.W(TW)) u_entry_tmr (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .run_in(state_reg == bmp_pkg::ST_WAIT),
    .count_in(TW'(bmp_pkg::BURST_ENTRY_CYC)), .done_out(entry_done)
  ); // RULE4
  bmp_delay_timer #(.W(TW)) u_wake_tmr (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .run_in(wake_reg), .count_in(TW'(bmp_pkg::WAKE_DLY_CYC)),
    .done_out(wake_done)
  ); // RULE15
  bmp_delay_timer #(.W(TW)) u_maxon_tmr (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .run_in(latch_reg && state_reg == bmp_pkg::ST_BURST),
    .count_in(TW'(MAX_ON_CYC)), .done_out(on_max)
  ); // RULE15

  // ----------------------------------------------------------------
  // Mode and fault decode
  // ----------------------------------------------------------------
  logic pwm_req, burst_req, fault_now, block, tick, fixed_mode;
  logic [bmp_pkg::FLT_W-1:0] det_mask;

  assign pwm_req = mode_level || (clk_present && ctrl_reg[bmp_pkg::CTRL_SYNC_EN]);
  assign burst_req = !pwm_req && ctrl_reg[bmp_pkg::CTRL_BURST_EN]; // RULE3
  assign det_mask = (state_reg == bmp_pkg::ST_BURST) ? bmp_pkg::DET_BURST
                                                     : bmp_pkg::DET_ALL; // RULE13
  assign fault_now = |(fault_s & det_mask);
  assign block = fault_now || shutdown || bias_s ||
                 (state_reg == bmp_pkg::ST_SLEEP); // RULE9 RULE1
  assign fixed_mode = (state_reg == bmp_pkg::ST_FIXED) ||
                      (state_reg == bmp_pkg::ST_WAIT) ||
                      (state_reg == bmp_pkg::ST_REDUCED);
  // A locked clock on the mode pin replaces the divider as cycle clock
  assign tick = (clk_present && ctrl_reg[bmp_pkg::CTRL_SYNC_EN]) ? sync_rise
              : (div_reg == 8'(OSC_DIV - 1)); // RULE7 RULE17

  always_comb begin
    state_next = state_reg;
    if (bias_s) begin
      state_next = bmp_pkg::ST_SLEEP; // RULE8
    end else if (shutdown) begin
      state_next = bmp_pkg::ST_SLEEP; // RULE5
    end else begin
      case (state_reg)
        bmp_pkg::ST_SLEEP: begin
          if (sleep_n_s) begin
            state_next = bmp_pkg::ST_FIXED; // RULE1
          end
        end
        bmp_pkg::ST_FIXED: begin
          if (burst_req && ss_ok_s && vout_ok_s) begin
            state_next = bmp_pkg::ST_WAIT; // RULE4
          end
        end
        bmp_pkg::ST_WAIT: begin
          if (!burst_req) begin
            state_next = bmp_pkg::ST_FIXED;
          end else if (entry_done) begin
            state_next = fault_now ? bmp_pkg::ST_REDUCED
                                   : bmp_pkg::ST_BURST; // RULE4 RULE6
          end
        end
        bmp_pkg::ST_BURST: begin
          if (!burst_req) begin
            state_next = bmp_pkg::ST_FIXED;
          end else if (fault_now) begin
            state_next = bmp_pkg::ST_REDUCED; // RULE6 RULE16
          end
        end
        bmp_pkg::ST_REDUCED: begin
          if (!burst_req) begin
            state_next = bmp_pkg::ST_FIXED;
          end
        end
        default: state_next = bmp_pkg::ST_SLEEP;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Switch latch and burst wake
  // ----------------------------------------------------------------
  logic set_req, rst_req;
  always_comb begin
    div_next = tick ? 8'h00 : div_reg + 8'h01;
    wake_next = wake_reg;
    if (state_reg != bmp_pkg::ST_BURST || block) begin
      wake_next = 1'b0;
    end else if (!wake_reg && !latch_reg && fb_below_s) begin
      wake_next = 1'b1; // RULE15
    end else if (wake_done) begin
      wake_next = 1'b0;
    end
    set_req = (fixed_mode && tick) ||
              (state_reg == bmp_pkg::ST_BURST && wake_done); // RULE10 RULE15
    // Comparator is only a few flops deep, so short pulses survive
    rst_req = cs_trip_s || block || on_max; // RULE10 RULE12
    // Reset wins over a simultaneous set: that period is skipped
    latch_next = (latch_reg || set_req) && !rst_req; // RULE11
  end

  // ----------------------------------------------------------------
  // Register access and interrupts
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    prdata_next = prdata;
    ack_next = psel && penable && !ack_reg;
    ev = '0;
    ev[bmp_pkg::EV_SLEEP] = (state_next == bmp_pkg::ST_SLEEP) &&
                            (state_reg != bmp_pkg::ST_SLEEP);
    ev[bmp_pkg::EV_BURST] = (state_next == bmp_pkg::ST_BURST) &&
                            (state_reg != bmp_pkg::ST_BURST);
    ev[bmp_pkg::EV_REDUCED] = (state_next == bmp_pkg::ST_REDUCED) &&
                              (state_reg != bmp_pkg::ST_REDUCED);
    ev[bmp_pkg::EV_BOOT_OV] = fault_s[bmp_pkg::FLT_BOOT_OV] &&
                              !flt_d_reg[bmp_pkg::FLT_BOOT_OV]; // RULE14
    ev[bmp_pkg::EV_BOOT_UV] = fault_s[bmp_pkg::FLT_BOOT_UV] &&
                              !flt_d_reg[bmp_pkg::FLT_BOOT_UV]; // RULE14
    ev[bmp_pkg::EV_SYNC] = clk_present != present_d_reg;
    irq_next = irq_reg | ev;
    if (psel && penable && !ack_reg) begin
      prdata_next = 32'h0000_0000;
      if (pwrite) begin
        prdata_next = 32'h0000_0000;
      end else if (paddr == bmp_pkg::REG_CTRL) begin
        prdata_next[1:0] = ctrl_reg;
      end else if (paddr == bmp_pkg::REG_STATUS) begin
        prdata_next[4:0] = state_reg;
        prdata_next[bmp_pkg::STAT_SYNC] = clk_present;
        prdata_next[bmp_pkg::STAT_GATE] = latch_reg;
      end else if (paddr == bmp_pkg::REG_IRQ_STAT) begin
        prdata_next[bmp_pkg::IRQ_W-1:0] = irq_reg;
      end else if (paddr == bmp_pkg::REG_IRQ_MASK) begin
        prdata_next[bmp_pkg::IRQ_W-1:0] = mask_reg;
      end
    end
    if (apb_done && pwrite) begin
      if (paddr == bmp_pkg::REG_CTRL) begin
        ctrl_next = pwdata[1:0];
      end else if (paddr == bmp_pkg::REG_IRQ_MASK) begin
        mask_next = pwdata[bmp_pkg::IRQ_W-1:0];
      end
    end else if (apb_done && paddr == bmp_pkg::REG_IRQ_STAT) begin
      // Clear only what was returned; new events still set
      irq_next = (irq_reg & ~prdata[bmp_pkg::IRQ_W-1:0]) | ev;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= bmp_pkg::ST_SLEEP;
      wake_reg <= 1'b0;
      latch_reg <= 1'b0;
      div_reg <= 8'h00;
      present_d_reg <= 1'b0;
      ctrl_reg <= bmp_pkg::CTRL_RST;
      mask_reg <= '0;
      irq_reg <= '0;
      prdata <= 32'h0000_0000;
      ack_reg <= 1'b0;
      comp_pull_out <= 1'b1;
      power_good_n_out <= 1'b0;
    end else if (ce_in) begin
      state_reg <= state_next;
      wake_reg <= wake_next;
      latch_reg <= latch_next;
      div_reg <= div_next;
      present_d_reg <= clk_present;
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
      prdata <= prdata_next;
      ack_reg <= ack_next;
      comp_pull_out <= block; // RULE9 RULE8
      power_good_n_out <= vout_ok_s && !bias_s && !shutdown; // RULE8
    end
  end

  assign hs_gate_out = latch_reg;
  assign ss_pull_out = comp_pull_out; // RULE8
  assign peak_current_limit_half_out = (state_reg == bmp_pkg::ST_REDUCED); // RULE6
  assign detectors_en_out = (state_reg != bmp_pkg::ST_BURST); // RULE16
  assign irq_out = |(irq_reg & mask_reg);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in || !ce_in);

  logic [TW-1:0] low_cnt_reg;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_cnt_reg <= '0;
    end else if (ce_in) begin
      low_cnt_reg <= sleep_n_s ? '0 : low_cnt_reg + 1'b1;
    end
  end

  sequence wake_start_s;
    $rose(wake_reg);
  endsequence
  sequence gate_quiet_s;
    !hs_gate_out [*8];
  endsequence

  latch_reset_dom_a: assert property (cs_trip_s |=> !hs_gate_out) // RULE11
    else $error("latch set while comparator reset active");
  short_pulse_a: assert property ($rose(hs_gate_out) && cs_trip_s |=> !hs_gate_out) // RULE12
    else $error("on-pulse not ended by comparator");
  fault_block_a: assert property (fault_now || shutdown |=> !hs_gate_out && comp_pull_out) // RULE9
    else $error("pulses not blocked on fault or shutdown");
  sleep_delay_a: assert property ($rose(shutdown) |-> low_cnt_reg >= TW'(SLEEP_DLY_CYC)) // RULE2
    else $error("shutdown before low level filter elapsed");
  shutdown_hold_a: assert property (shutdown && !bias_s // RULE5
    |=> state_reg == bmp_pkg::ST_SLEEP && !hs_gate_out)
    else $error("mode input acted during shutdown");
  burst_entry_a: assert property ($rose(state_reg == bmp_pkg::ST_BURST) // RULE4
    |-> $past(state_reg == bmp_pkg::ST_WAIT) && $past(entry_done))
    else $error("burst entered without entry delay");
  reduced_entry_a: assert property (state_reg == bmp_pkg::ST_BURST && // RULE6
    fault_now && burst_req && !shutdown && !bias_s
    |=> peak_current_limit_half_out && detectors_en_out)
    else $error("fault in burst did not give reduced limit");
  cycle_set_a: assert property (fixed_mode && tick && !rst_req |=> hs_gate_out) // RULE10
    else $error("cycle clock did not set the switch latch");
  bias_reset_a: assert property (bias_s // RULE8
    |=> !power_good_n_out && !hs_gate_out && ss_pull_out)
    else $error("bias loss did not reset outputs");
  wake_delay_a: assert property (wake_start_s |-> gate_quiet_s) // RULE15
    else $error("switch turned on before wake delay");
  boot_flag_a: assert property ($rose(fault_s[bmp_pkg::FLT_BOOT_OV]) // RULE14
    |=> irq_reg[bmp_pkg::EV_BOOT_OV])
    else $error("boot overvoltage not flagged");
endmodule // bmp_mode_ctrl

// ### bmp_host_model.sv
// Host model that drives the shutdown and mode-select pins.
// Assumes the bench asks for levels; a sync clock replaces the mode level on request.
`timescale 1ns/100ps
module bmp_host_model (
  // Requests from the bench
  input wire logic sleep_req_in,
  input wire logic mode_req_in,
  input wire logic sync_req_in,
  // Pins
  output logic sleep_n_out,
  output logic mode_out
);
  logic sclk = 1'b0;
  // Phase offset keeps the sync clock edges 3 ns after the reference clock edges, never on them
  initial begin
    #33;
    // 160 ns period; the bench sets the base period so the ratio stays in band
    forever #80 sclk = ~sclk;
  end
  assign sleep_n_out = sleep_req_in;
  // Clock only while sync is requested, otherwise a steady level
  assign mode_out = sync_req_in ? sclk : mode_req_in;
endmodule // bmp_host_model

// ### bmp_mode_ctrl_test.sv
// Self-checking bench of the mode control: APB, pins, latch and interrupt.
// Assumes a 20-cycle shutdown filter and an 11-cycle base period (sync 1.375x base).
`timescale 1ns/100ps
module bmp_mode_ctrl_test;
  logic ref_clk_in = 1'b0, rst_n_in = 1'b0, ce_in = 1'b1, cs_trip_in = 1'b0;
  logic fb_below_ref_in = 1'b0, ss_above_thr_in = 1'b1, vout_ok_in = 1'b1, bias_lost_in = 1'b0;
  logic [3:0] fault_in = 4'h0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hF535;
  logic pready, pslverr, err, hs_gate_out, comp_pull_out, ss_pull_out, power_good_n_out;
  logic peak_current_limit_half_out, detectors_en_out, irq_out, sleep_n_in, mode_select_sync_in;
  logic sleep_req = 1'b0, mode_req = 1'b1, sync_req = 1'b0;
  int failures = 0, samples_checked = 0, n, hi;
  always #10 ref_clk_in = ~ref_clk_in;
  bmp_host_model host (.sleep_req_in(sleep_req), .mode_req_in(mode_req),
    .sync_req_in(sync_req), .sleep_n_out(sleep_n_in), .mode_out(mode_select_sync_in));
  bmp_mode_ctrl #(.SLEEP_DLY_CYC(20), .OSC_DIV(11)) uut (.ref_clk_in, .ce_in, .rst_n_in,
    .sleep_n_in, .mode_select_sync_in, .cs_trip_in, .fb_below_ref_in, .ss_above_thr_in,
    .vout_ok_in, .bias_lost_in, .fault_in, .hs_gate_out, .comp_pull_out, .ss_pull_out,
    .power_good_n_out, .peak_current_limit_half_out, .detectors_en_out, .irq_out, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [31:0] st(input logic [4:0] s);
    return {27'h0, s};
  endfunction
  function automatic logic irq_exp(input logic [5:0] s, input logic [5:0] m);
    return |(s & m);
  endfunction
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Checks run 2 ns after the edge so flops have settled
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_in);
    #2;
  endtask
  // Waits a bounded time for pready; data and error are taken at the completing edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int c;
    @(posedge ref_clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    c = 0;
    do begin
      @(posedge ref_clk_in);
      c++;
    end while (pready !== 1'b1 && c < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (c >= 50) failures++;
    #2;
  endtask
  task automatic wgate(input logic v);
    n = 0;
    while (hs_gate_out !== v && n < 400) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic wrap_up();
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(20);
    rst_n_in <= 1'b1;
    apb(0, 8'h00, 0); chk_reg(rd, 32'h3);
    apb(0, 8'h04, 0); chk_reg(rd & 32'h1F, st(5'h01));
    chk_bit(comp_pull_out, 1'b1);
    seed = xs(seed);
    apb(1, 8'h0C, seed); apb(0, 8'h0C, 0); chk_reg(rd, seed & 32'h3F);
    apb(1, 8'h0C, 32'h3F); apb(0, 8'h08, 0);
    sleep_req <= 1'b1; cyc(10);
    apb(0, 8'h04, 0); chk_reg(rd & 32'h1F, st(5'h02));
    chk_bit(comp_pull_out, 1'b0); chk_bit(power_good_n_out, 1'b1);
    wgate(1); chk_bit(n < 60, 1'b1);
    cs_trip_in <= 1'b1; wgate(0); chk_bit(n <= 6, 1'b1);
    hi = 0;
    repeat (100) begin cyc(1); if (hs_gate_out !== 1'b0) hi++; end
    chk_reg(hi, 0);
    cs_trip_in <= 1'b0;
    seed = xs(seed);
    sleep_req <= 1'b0; cyc(5 + seed[3:0] % 10); sleep_req <= 1'b1; cyc(10);
    apb(0, 8'h04, 0); chk_reg(rd & 32'h1F, st(5'h02));
    mode_req <= 1'b0; cyc(10);
    apb(0, 8'h04, 0); chk_reg(rd & 32'h1F, st(5'h04));
    cyc(2060);
    apb(0, 8'h04, 0); chk_reg(rd & 32'h1F, st(5'h08));
    chk_bit(detectors_en_out, 1'b0); chk_bit(irq_out, irq_exp(6'h02, 6'h3F));
    apb(0, 8'h08, 0); chk_reg(rd & 32'h3F, 32'h02); chk_bit(irq_out, 1'b0);
    wgate(0); fb_below_ref_in <= 1'b1; wgate(1);
    chk_bit(n >= bmp_pkg::WAKE_DLY_CYC && n <= bmp_pkg::WAKE_DLY_CYC + 8, 1'b1);
    fb_below_ref_in <= 1'b0; fault_in <= 4'h3; cyc(10);
    apb(0, 8'h04, 0); chk_reg(rd & 32'h1F, st(5'h10));
    chk_bit(peak_current_limit_half_out, 1'b1); chk_bit(detectors_en_out, 1'b1);
    apb(0, 8'h08, 0); chk_reg(rd & 32'h1C, 32'h1C);
    fault_in <= 4'h0; mode_req <= 1'b1; cyc(10);
    apb(0, 8'h04, 0); chk_reg(rd & 32'h1F, st(5'h02));
    chk_bit(peak_current_limit_half_out, 1'b0); chk_bit(detectors_en_out, 1'b1);
    sync_req <= 1'b1; cyc(200);
    apb(0, 8'h04, 0); chk_reg(rd & 32'h20, 32'h20);
    sync_req <= 1'b0; cyc(200); apb(0, 8'h08, 0);
    apb(0, 8'h10, 0); chk_reg(rd, 32'h0); chk_bit(err, 1'b1);
    apb(1, 8'h0C, 32'h0); sleep_req <= 1'b0; mode_req <= 1'b0; cyc(40);
    apb(0, 8'h04, 0); chk_reg(rd & 32'h1F, st(5'h01));
    chk_bit(hs_gate_out, 1'b0); chk_bit(comp_pull_out, 1'b1);
    chk_bit(irq_out, irq_exp(6'h01, 6'h00));
    apb(1, 8'h0C, 32'h3F); cyc(1); chk_bit(irq_out, irq_exp(6'h01, 6'h3F));
    apb(0, 8'h08, 0); chk_reg(rd & 32'h3F, 32'h01); chk_bit(irq_out, 1'b0);
    mode_req <= 1'b1; sleep_req <= 1'b1; cyc(10); bias_lost_in <= 1'b1; cyc(6);
    apb(0, 8'h04, 0); chk_reg(rd & 32'h1F, st(5'h01));
    chk_bit(comp_pull_out, 1'b1); chk_bit(ss_pull_out, 1'b1);
    chk_bit(power_good_n_out, 1'b0); chk_bit(hs_gate_out, 1'b0);
    bias_lost_in <= 1'b0;
    wrap_up();
  end
  initial begin
    #(20 * 20000);
    failures++;
    wrap_up();
  end
endmodule // bmp_mode_ctrl_test
